//--- tec_defines.vh
// Register map, field layout and constants of the dual timer/event counter
`ifndef TEC_DEFINES_VH
`define TEC_DEFINES_VH

// Wishbone word indices (byte address = 4 * index)
`define TEC_IDX_T0_COUNT   6'h00
`define TEC_IDX_T1_COUNT   6'h01
`define TEC_IDX_T0_CONTROL 6'h02
`define TEC_IDX_T1_CONTROL 6'h03
`define TEC_IDX_IRQ_ENABLE 6'h04
`define TEC_IDX_OVF_STATUS 6'h05

// Control register fields
`define TEC_MODE_HI        7
`define TEC_MODE_LO        6
`define TEC_RUN_BIT        4
`define TEC_EDGE_BIT       3
`define TEC_PSC_HI         2
`define TEC_PSC_LO         0

// Mode field codes
`define TEC_MODE_TIMER     2'h2
`define TEC_MODE_EVENT     2'h1
`define TEC_MODE_PULSE     2'h3

// Writable bits of each control register, reserved bits read zero
`define TEC_CTL0_MASK      8'hDF
`define TEC_CTL1_MASK      8'hD8

// Reset values
`define TEC_CTL_RST        8'h00
`define TEC_CNT_RST        8'h00
`define TEC_PRE_RST        8'h00
`define TEC_IEN_RST        2'h0
`define TEC_STAT_RST       2'h0
`define TEC_DAT_RST        32'h00000000

// Misc widths and values
`define TEC_CNT_FULL       8'hFF
`define TEC_RD_PAD         24'h000000
`define TEC_RD_PAD2        6'h00
`define TEC_PSC_ALL        8'hFF
`define TEC_PSC_TOP        3'h7
`define TEC_PSC_RST        8'h00

// Idle level of a timer input pin with its pull-high
`define TEC_PIN_IDLE       1'b1

`endif

//--- tec_edge_sync.v
// Two-flop synchroniser with edge detection for a timer input pin
`timescale 1ns/10ps
`include "tec_defines.vh"

module tec_edge_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire rstn,
  // Raw pin
  input  wire pinIn,
  // Synchronised level and edges
  output wire pinLevel,
  output wire pinRise,
  output wire pinFall
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      // Reset to the idle level so no false edge follows reset
      meta_q <= `TEC_PIN_IDLE;
      sync_q <= `TEC_PIN_IDLE;
      prev_q <= `TEC_PIN_IDLE;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pinLevel = sync_q;
  assign pinRise  = sync_q & ~prev_q;
  assign pinFall  = ~sync_q & prev_q;

endmodule

//--- tec_prescaler.v
// Eight-stage prescaler giving a divided internal count tick
`timescale 1ns/10ps
`include "tec_defines.vh"

module tec_prescaler (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rstn,
  // Division select, ratio is 2 to the power (ratio + 1)
  input  wire [2:0] ratio,
  // One-cycle tick at the falling edge of the selected stage
  output wire       tick
);

  reg  [7:0] stage_q;
  wire [7:0] stageMask;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      stage_q <= `TEC_PSC_RST;
    end else begin
      stage_q <= stage_q + 8'h01;
    end
  end

  // Selected stage falls when all stages up to it are ones
  assign stageMask = `TEC_PSC_ALL >> (`TEC_PSC_TOP - ratio);
  assign tick      = &(stage_q | ~stageMask);

endmodule

//--- tec_timer_top.v
// Dual 8-bit timer/event counter with Wishbone register access
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "tec_defines.vh"

module tec_timer_top (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // External timer inputs and power state
  input  wire        ctr0ExtInputPin,
  input  wire        ctr1ExtInputPin,
  input  wire        powerDown,
  // Interrupt and wake-up requests
  output reg         ctr0IrqReq,
  output reg         ctr1IrqReq,
  output reg         wakeReq
);

  // Per-channel register values and shared registers
  wire [7:0] cntVal [0:1];
  wire [7:0] ctlVal [0:1];
  reg  [1:0] ien_q;
  reg  [1:0] stat_q;

  // Bus decode
  wire       accessReq;
  wire [5:0] wordIdx;
  wire       wrNow;
  wire       rdTake;
  wire [1:0] hitCount;
  wire [1:0] hitCtrl;
  wire       hitIen;
  wire       hitStat;
  wire [7:0] ctlMask [0:1];

  // Pin and clock sources
  wire [1:0] pinLvl;
  wire [1:0] pinRise;
  wire [1:0] pinFall;
  wire       pscTick;
  wire [1:0] intTick;

  // Per-channel decoded control
  wire [1:0] runOn;
  wire [1:0] edgeSel;
  wire [1:0] isTimer;
  wire [1:0] isEvent;
  wire [1:0] isPulse;
  wire [1:0] actLvl;
  wire [1:0] evEdge;
  wire [1:0] pwStart;
  wire [1:0] pwEnd;
  wire [1:0] inhibit;
  wire [1:0] step;
  wire [1:0] ovfNow;
  reg  [7:0] rdByte;

  assign accessReq = wb_cyc_i & wb_stb_i;
  assign wordIdx   = wb_adr_i[7:2];
  // Writes land on the edge where the master sees ack
  assign wrNow     = accessReq & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign rdTake    = accessReq & ~wb_ack_o;

  assign hitCount[0] = (wordIdx == `TEC_IDX_T0_COUNT);
  assign hitCount[1] = (wordIdx == `TEC_IDX_T1_COUNT);
  assign hitCtrl[0]  = (wordIdx == `TEC_IDX_T0_CONTROL);
  assign hitCtrl[1]  = (wordIdx == `TEC_IDX_T1_CONTROL);
  assign hitIen      = (wordIdx == `TEC_IDX_IRQ_ENABLE);
  assign hitStat     = (wordIdx == `TEC_IDX_OVF_STATUS);

  assign ctlMask[0] = `TEC_CTL0_MASK;
  assign ctlMask[1] = `TEC_CTL1_MASK;

  // Pin synchronisers
  tec_edge_sync u_sync0 (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .pinIn    (ctr0ExtInputPin),
    .pinLevel (pinLvl[0]),
    .pinRise  (pinRise[0]),
    .pinFall  (pinFall[0])
  );

  tec_edge_sync u_sync1 (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .pinIn    (ctr1ExtInputPin),
    .pinLevel (pinLvl[1]),
    .pinRise  (pinRise[1]),
    .pinFall  (pinFall[1])
  );

  // Counter 0 internal clock through the prescaler
  tec_prescaler u_psc0 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ratio   (ctlVal[0][`TEC_PSC_HI:`TEC_PSC_LO]),
    .tick    (pscTick)
  );

  // Internal clock stops in power-down; counter 1 is undivided
  assign intTick[0] = pscTick & ~powerDown;
  assign intTick[1] = ~powerDown;

  // Per-channel counter slices
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      reg  [7:0] cnt_q;
      reg  [7:0] pre_q;
      reg  [7:0] ctl_q;
      reg        busy_q;
      wire [1:0] modeSel;
      wire       ctlWr;
      wire       cntWr;
      wire       endEdge;
      wire       timerStep;
      wire       eventStep;
      wire       pulseStep;

      // Register write strobes
      assign ctlWr = wrNow & hitCtrl[g];
      assign cntWr = wrNow & hitCount[g];

      // Mode decode
      assign modeSel    = ctl_q[`TEC_MODE_HI:`TEC_MODE_LO];
      assign runOn[g]   = ctl_q[`TEC_RUN_BIT];
      assign edgeSel[g] = ctl_q[`TEC_EDGE_BIT];
      assign isTimer[g] = (modeSel == `TEC_MODE_TIMER);
      assign isEvent[g] = (modeSel == `TEC_MODE_EVENT);
      assign isPulse[g] = (modeSel == `TEC_MODE_PULSE);

      // Pin conditions; pulse edge 0 is a low pulse, edge 1 a high pulse
      assign evEdge[g]  = edgeSel[g] ? pinFall[g] : pinRise[g];
      assign actLvl[g]  = edgeSel[g] ? pinLvl[g] : ~pinLvl[g];
      assign pwStart[g] = edgeSel[g] ? pinRise[g] : pinFall[g];
      assign endEdge    = edgeSel[g] ? pinFall[g] : pinRise[g];
      assign pwEnd[g]   = busy_q & isPulse[g] & endEdge;

      // Counting clock of each mode, suppressed during count access
      assign inhibit[g] = accessReq & hitCount[g];
      assign timerStep  = isTimer[g] & intTick[g];
      assign eventStep  = isEvent[g] & evEdge[g];
      assign pulseStep  = isPulse[g] & busy_q & actLvl[g] & ~pwEnd[g] & intTick[g];
      assign step[g]    = runOn[g] & ~inhibit[g] & (timerStep | eventStep | pulseStep);
      assign ovfNow[g]  = step[g] & (cnt_q == `TEC_CNT_FULL);

      // Values seen by the read mux and prescaler
      assign cntVal[g] = cnt_q;
      assign ctlVal[g] = ctl_q;

      // Control register; software write wins over the run-bit clear
      always @(posedge ref_clk) begin
        if (!rstn) begin
          ctl_q <= `TEC_CTL_RST;
        end else if (ctlWr) begin
          ctl_q <= wb_dat_i[7:0] & ctlMask[g];
        end else if (pwEnd[g]) begin
          ctl_q[`TEC_RUN_BIT] <= 1'b0;
        end
      end

      // Pulse measurement arms on the start edge only
      always @(posedge ref_clk) begin
        if (!rstn) begin
          busy_q <= 1'b0;
        end else if (~runOn[g] | ~isPulse[g] | pwEnd[g]) begin
          busy_q <= 1'b0;
        end else if (pwStart[g]) begin
          busy_q <= 1'b1;
        end
      end

      // Preload register takes every count write
      always @(posedge ref_clk) begin
        if (!rstn) begin
          pre_q <= `TEC_PRE_RST;
        end else if (cntWr) begin
          pre_q <= wb_dat_i[7:0];
        end
      end

      // Counter: direct load only while stopped
      always @(posedge ref_clk) begin
        if (!rstn) begin
          cnt_q <= `TEC_CNT_RST;
        end else if (cntWr & ~runOn[g]) begin
          cnt_q <= wb_dat_i[7:0];
        end else if (ovfNow[g]) begin
          cnt_q <= pre_q;
        end else if (step[g]) begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  endgenerate

  // Interrupt enables and sticky overflow status
  always @(posedge ref_clk) begin
    if (!rstn) begin
      ien_q  <= `TEC_IEN_RST;
      stat_q <= `TEC_STAT_RST;
    end else begin
      if (wrNow & hitIen) begin
        ien_q <= wb_dat_i[1:0];
      end
      // Set wins over write-one-to-clear
      if (wrNow & hitStat) begin
        stat_q <= (stat_q & ~wb_dat_i[1:0]) | ovfNow;
      end else begin
        stat_q <= stat_q | ovfNow;
      end
    end
  end

  // Request outputs
  always @(posedge ref_clk) begin
    if (!rstn) begin
      ctr0IrqReq <= 1'b0;
      ctr1IrqReq <= 1'b0;
      wakeReq    <= 1'b0;
    end else begin
      ctr0IrqReq <= ovfNow[0] & ien_q[0];
      ctr1IrqReq <= ovfNow[1] & ien_q[1];
      wakeReq    <= |ovfNow;
    end
  end

  // Read mux
  always @* begin
    rdByte = `TEC_CNT_RST;
    case (wordIdx)
      `TEC_IDX_T0_COUNT:   rdByte = cntVal[0];
      `TEC_IDX_T1_COUNT:   rdByte = cntVal[1];
      `TEC_IDX_T0_CONTROL: rdByte = ctlVal[0];
      `TEC_IDX_T1_CONTROL: rdByte = ctlVal[1];
      `TEC_IDX_IRQ_ENABLE: rdByte = {`TEC_RD_PAD2, ien_q};
      `TEC_IDX_OVF_STATUS: rdByte = {`TEC_RD_PAD2, stat_q};
      default:             rdByte = `TEC_CNT_RST;
    endcase
  end

  // Wishbone answer: ack one cycle after the request
  always @(posedge ref_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `TEC_DAT_RST;
    end else begin
      wb_ack_o <= rdTake;
      if (rdTake) begin
        wb_dat_o <= {`TEC_RD_PAD, rdByte};
      end
    end
  end

endmodule

//--- tec_timer_top_props.sv
// Port checker for the timer/event counter
`timescale 1ns/10ps
`include "tec_defines.vh"
module tec_timer_top_props (
  // Clock and reset
  input wire        ref_clk,
  input wire        rstn,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Requests
  input wire        ctr0IrqReq,
  input wire        ctr1IrqReq,
  input wire        wakeReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire rdAck = wb_ack_o && !wb_we_i;
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_read_pad: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_ctl1_reserved: assert property (rdAck && wb_adr_i[7:2] == 6'h03 |->
    (wb_dat_o[7:0] & ~`TEC_CTL1_MASK) == 8'h00) else $error("reserved bits set");
  a_unmapped_zero: assert property (rdAck && wb_adr_i[7:2] > 6'h05 |-> wb_dat_o == 32'h0)
    else $error("unmapped read");
  a_irq0_wake: assert property (ctr0IrqReq |-> wakeReq)
    else $error("irq0 without wake");
  a_irq1_wake: assert property (ctr1IrqReq |-> wakeReq)
    else $error("irq1 without wake");
  a_irq0_gap: assert property (ctr0IrqReq |=> !ctr0IrqReq)
    else $error("irq0 back to back");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !wb_ack_o && !wakeReq && !ctr0IrqReq && !ctr1IrqReq)
    else $error("outputs active in reset");
endmodule
bind tec_timer_top tec_timer_top_props u_props (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .ctr0IrqReq, .ctr1IrqReq, .wakeReq);

//--- tec_pin_source.sv
// Source model for the two external timer pins
`timescale 1ns/10ps
module tec_pin_source (
  // Clock
  input  wire  ref_clk,
  // Pins
  output logic ctr0Pin,
  output logic ctr1Pin
);
  // Pins idle high as with a pull-high
  initial begin
    ctr0Pin = 1'b1;
    ctr1Pin = 1'b1;
  end
  // Drive a pin as an input level and hold it
  task automatic drive(input int ch, input logic v, input int hold);
    @(posedge ref_clk);
    if (ch == 0)
      ctr0Pin <= v;
    else
      ctr1Pin <= v;
    repeat (hold) @(posedge ref_clk);
  endtask
endmodule

//--- tec_timer_top_tb_top.sv
// Register-level bench for the timer/event counter
`timescale 1ns/10ps
module tec_timer_top_tb_top;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] datI = 32'h0;
  logic [31:0] datO;
  logic        ack;
  logic        pin0;
  logic        pin1;
  logic        powerDown = 1'b0;
  logic        irq0;
  logic        irq1;
  logic        wake;
  logic [31:0] rd;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n;
  always #5 ref_clk = ~ref_clk;
  tec_pin_source src (.ref_clk(ref_clk), .ctr0Pin(pin0), .ctr1Pin(pin1));
  tec_timer_top dut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .ctr0ExtInputPin(pin0), .ctr1ExtInputPin(pin1), .powerDown(powerDown),
    .ctr0IrqReq(irq0), .ctr1IrqReq(irq1), .wakeReq(wake));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic cycle, released at the edge where ack is taken
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    datI <= {24'h000000, d};
    do @(posedge ref_clk); while (ack !== 1'b1);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Cycles until the chosen request pulses
  task automatic waitFor(input int s, output int k);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while ((s == 0 ? irq0 : s == 1 ? irq1 : wake) !== 1'b1);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int a = 0; a < 28; a += 4) begin
      wb(1'b0, a[7:0], 8'h00);
      chk("reset", rd, 32'h0);
    end
    wb(1'b1, 8'h00, 8'hF0);
    wb(1'b0, 8'h00, 8'h00);
    chk("load", rd, 32'hF0);
    wb(1'b1, 8'h0C, 8'hFF);
    wb(1'b0, 8'h0C, 8'h00);
    chk("ctl1", rd, 32'hD8);
    wb(1'b1, 8'h0C, 8'h00);
    $display("test regs done");
    wb(1'b1, 8'h10, 8'h03);
    wb(1'b1, 8'h04, 8'hF0);
    wb(1'b1, 8'h0C, 8'h80);
    wb(1'b1, 8'h0C, 8'h90);
    waitFor(1, n);
    wb(1'b1, 8'h04, 8'hC0);
    waitFor(1, n);
    chk("held", n, 32'h10);
    waitFor(1, n);
    chk("period1", n, 64);
    wb(1'b0, 8'h14, 8'h00);
    chk("status", rd, 32'h2);
    wb(1'b1, 8'h0C, 8'h00);
    $display("test timer1 done");
    for (int p = 0; p < 3; p++) begin
      wb(1'b1, 8'h08, 8'h80 | p[7:0]);
      wb(1'b1, 8'h08, 8'h90 | p[7:0]);
      waitFor(0, n);
      waitFor(0, n);
      chk("period0", n, 16 << (p + 1));
      wb(1'b1, 8'h08, 8'h00);
    end
    wb(1'b1, 8'h10, 8'h00);
    wb(1'b1, 8'h08, 8'h80);
    wb(1'b1, 8'h08, 8'h90);
    waitFor(2, n);
    chk("masked", irq0, 1'b0);
    wb(1'b1, 8'h08, 8'h00);
    $display("test timer0 done");
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, 8'h08, 8'h40 | (e[7:0] << 3));
      wb(1'b1, 8'h00, 8'h00);
      wb(1'b1, 8'h08, 8'h50 | (e[7:0] << 3));
      powerDown <= 1'b1;
      src.drive(0, 1'b0, 6);
      src.drive(0, 1'b1, 6);
      src.drive(0, 1'b0, 6);
      powerDown <= 1'b0;
      wb(1'b1, 8'h08, 8'h40);
      wb(1'b0, 8'h00, 8'h00);
      chk("events", rd, e ? 32'h2 : 32'h1);
      src.drive(0, 1'b1, 6);
    end
    $display("test event done");
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h0C, 8'hC0);
    wb(1'b1, 8'h0C, 8'hD0);
    src.drive(1, 1'b0, 20);
    src.drive(1, 1'b1, 6);
    wb(1'b0, 8'h0C, 8'h00);
    chk("runclr", rd, 32'hC0);
    src.drive(1, 1'b0, 6);
    src.drive(1, 1'b1, 6);
    wb(1'b0, 8'h04, 8'h00);
    chk("width", rd > 18 && rd < 24, 1);
    $display("test pulse done");
    summarize();
  end
endmodule
